//--- logic/dmscp_map.vh
`ifndef DMSCP_MAP_VH
`define DMSCP_MAP_VH

// Own 2-wire slave address, upper six bits; the low bit comes from the strap
`define DMSCP_SLAVE_ADDR_HI    6'h0e
// Register index whose write returns all registers to defaults
`define DMSCP_REG_SW_RESET     16'h0000
// Width of a register index and of a register value
`define DMSCP_IDX_W            16
`define DMSCP_DATA_W           16
// Bits in one 3-wire frame
`define DMSCP_FRAME_W          32

// Reset values
`define DMSCP_PIN_RST          4'hf
`define DMSCP_IDX_RST          16'h0000

// Core clock period and least power-on hold time
`define DMSCP_CLK_PERIOD_NS    10
`define DMSCP_POR_TIME_NS      6000
// Least time rounds up to whole cycles
`define DMSCP_POR_CYCLES       ((`DMSCP_POR_TIME_NS + `DMSCP_CLK_PERIOD_NS - 1) / `DMSCP_CLK_PERIOD_NS)

// Byte position within a 2-wire write
`define DMSCP_WB_IDX_HI        2'd0
`define DMSCP_WB_IDX_LO        2'd1
`define DMSCP_WB_DAT_HI        2'd2
`define DMSCP_WB_DAT_LO        2'd3

`endif

//--- logic/dmscp_port.v
`timescale 1ns/1ns
`default_nettype none
`include "dmscp_map.vh"

module dmscp_port (
    input  wire        clk,
    input  wire        srst,
    input  wire        mode_strap,
    input  wire        select_addr_strap,
    input  wire        scl_in,
    input  wire        sda_in,
    output wire        sda_out,
    output wire        sda_oe,
    output wire [15:0] reg_rd_idx,
    input  wire [15:0] reg_rd_data,
    output wire        reg_wr,
    output wire [15:0] reg_wr_idx,
    output wire [15:0] reg_wr_data,
    output wire        sw_reset,
    output wire        por_done
);

    localparam [2:0] ST_IDLE = 3'd0;
    localparam [2:0] ST_ADDR = 3'd1;
    localparam [2:0] ST_AACK = 3'd2;
    localparam [2:0] ST_WRX  = 3'd3;
    localparam [2:0] ST_WACK = 3'd4;
    localparam [2:0] ST_TX   = 3'd5;
    localparam [2:0] ST_TACK = 3'd6;
    localparam [2:0] ST_IGN  = 3'd7;
    localparam [31:0]  POR_LAST32 = `DMSCP_POR_CYCLES - 1;
    localparam [9:0]   POR_LAST = POR_LAST32[9:0];
    // Pin index within the synchroniser vectors
    localparam MODE_B = 3;
    localparam CS_B   = 2;
    localparam SCL_B  = 1;
    localparam SDA_B  = 0;

    reg  [3:0]  sy1_r;
    reg  [3:0]  sy2_r;
    reg  [3:0]  sy3_r;
    reg  [3:0]  filt_r;
    reg  [3:0]  prev_r;
    wire [3:0]  agree;
    wire        scl_rise;
    wire        scl_fall;
    wire        sda_rise;
    wire        sda_fall;
    wire        cs_rise;
    wire        two_wire;
    wire        start_det;
    wire        stop_det;
    wire [6:0]  own_addr;
    reg  [2:0]  state_r;
    reg  [3:0]  bit_cnt_r;
    reg  [7:0]  rx_sh_r;
    reg  [7:0]  tx_sh_r;
    reg         rw_r;
    reg  [1:0]  wbyte_r;
    reg         byte_sel_r;
    reg  [15:0] idx_r;
    reg  [7:0]  dat_hi_r;
    reg  [15:0] hold_r;
    reg         ack_seen_r;
    reg         sda_low_r;
    reg  [31:0] frame_r;
    reg         wr_r;
    reg  [15:0] wr_idx_r;
    reg  [15:0] wr_data_r;
    reg         swr_r;
    reg  [9:0]  por_cnt_r;
    reg         por_done_r;
    reg         wr_req;
    reg  [15:0] wr_req_idx;
    reg  [15:0] wr_req_data;

    // Three-stage pin capture; a level counts once stages two and three agree
    always @(posedge clk) begin
        if (srst) begin
            sy1_r  <= `DMSCP_PIN_RST;
            sy2_r  <= `DMSCP_PIN_RST;
            sy3_r  <= `DMSCP_PIN_RST;
            filt_r <= `DMSCP_PIN_RST;
            prev_r <= `DMSCP_PIN_RST;
        end else begin
            sy1_r  <= {mode_strap, select_addr_strap, scl_in, sda_in};
            sy2_r  <= sy1_r;
            sy3_r  <= sy2_r;
            filt_r <= (sy2_r & agree) | (filt_r & ~agree);
            prev_r <= filt_r;
        end
    end

    assign agree    = ~(sy2_r ^ sy3_r);
    assign scl_rise = filt_r[SCL_B] & ~prev_r[SCL_B];
    assign scl_fall = ~filt_r[SCL_B] & prev_r[SCL_B];
    assign sda_rise = filt_r[SDA_B] & ~prev_r[SDA_B];
    assign sda_fall = ~filt_r[SDA_B] & prev_r[SDA_B];
    assign cs_rise  = filt_r[CS_B] & ~prev_r[CS_B];
    assign two_wire = filt_r[MODE_B];
    assign start_det = two_wire & sda_fall & filt_r[SCL_B] & prev_r[SCL_B];
    assign stop_det  = two_wire & sda_rise & filt_r[SCL_B] & prev_r[SCL_B];
    // strap picks the address low bit
    assign own_addr  = {`DMSCP_SLAVE_ADDR_HI, filt_r[CS_B]};

    // Power-on hold; counts from reset release, no timeout elsewhere
    // power-on hold
    always @(posedge clk) begin
        if (srst) begin
            por_cnt_r  <= 10'h000;
            por_done_r <= 1'b0;
        end else if (!por_done_r) begin
            por_cnt_r  <= por_cnt_r + 10'h001;
            por_done_r <= (por_cnt_r == POR_LAST);
        end
    end

    // Two-wire slave engine; sample on clock rise, change data on clock fall
    always @(posedge clk) begin
        if (srst) begin
            state_r    <= ST_IDLE;
            bit_cnt_r  <= 4'h0;
            rx_sh_r    <= 8'h00;
            tx_sh_r    <= 8'h00;
            rw_r       <= 1'b0;
            wbyte_r    <= `DMSCP_WB_IDX_HI;
            byte_sel_r <= 1'b0;
            idx_r      <= `DMSCP_IDX_RST;
            dat_hi_r   <= 8'h00;
            hold_r     <= 16'h0000;
            ack_seen_r <= 1'b0;
            sda_low_r  <= 1'b0;
        end else if (!two_wire || stop_det) begin
            state_r   <= ST_IDLE;
            sda_low_r <= 1'b0;
        end else if (start_det) begin
            state_r   <= ST_ADDR;
            bit_cnt_r <= 4'h0;
            sda_low_r <= 1'b0;
        end else if (scl_rise) begin
            // Receive path and host acknowledge sampling
            if (state_r == ST_ADDR || state_r == ST_WRX) begin
                rx_sh_r   <= {rx_sh_r[6:0], filt_r[SDA_B]};
                bit_cnt_r <= bit_cnt_r + 4'h1;
            end else if (state_r == ST_TACK) begin
                ack_seen_r <= ~filt_r[SDA_B];
            end
        end else if (scl_fall) begin
            case (state_r)
                ST_ADDR: begin
                    if (bit_cnt_r == 4'h8) begin
                        if (rx_sh_r[7:1] == own_addr) begin
                            sda_low_r <= 1'b1;
                            rw_r      <= rx_sh_r[0];
                            state_r   <= ST_AACK;
                        end else begin
                            state_r <= ST_IGN;
                        end
                    end
                end
                ST_AACK: begin
                    bit_cnt_r <= 4'h0;
                    if (rw_r) begin
                        hold_r     <= reg_rd_data;
                        tx_sh_r    <= {reg_rd_data[14:8], 1'b0};
                        sda_low_r  <= ~reg_rd_data[15];
                        bit_cnt_r  <= 4'h1;
                        byte_sel_r <= 1'b0;
                        state_r    <= ST_TX;
                    end else begin
                        sda_low_r <= 1'b0;
                        wbyte_r   <= `DMSCP_WB_IDX_HI;
                        state_r   <= ST_WRX;
                    end
                end
                ST_WRX: begin
                    if (bit_cnt_r == 4'h8) begin
                        sda_low_r <= 1'b1;
                        state_r   <= ST_WACK;
                        case (wbyte_r)
                            `DMSCP_WB_IDX_HI: begin
                                idx_r[15:8] <= rx_sh_r;
                                wbyte_r     <= `DMSCP_WB_IDX_LO;
                            end
                            `DMSCP_WB_IDX_LO: begin
                                idx_r[7:0] <= rx_sh_r;
                                wbyte_r    <= `DMSCP_WB_DAT_HI;
                            end
                            `DMSCP_WB_DAT_HI: begin
                                dat_hi_r <= rx_sh_r;
                                wbyte_r  <= `DMSCP_WB_DAT_LO;
                            end
                            default: begin
                                // Later words go to following indices
                                idx_r   <= idx_r + 16'h0001;
                                wbyte_r <= `DMSCP_WB_DAT_HI;
                            end
                        endcase
                    end
                end
                ST_WACK: begin
                    sda_low_r <= 1'b0;
                    bit_cnt_r <= 4'h0;
                    state_r   <= ST_WRX;
                end
                ST_TX: begin
                    if (bit_cnt_r == 4'h8) begin
                        sda_low_r <= 1'b0;
                        state_r   <= ST_TACK;
                    end else begin
                        sda_low_r <= ~tx_sh_r[7];
                        tx_sh_r   <= {tx_sh_r[6:0], 1'b0};
                        bit_cnt_r <= bit_cnt_r + 4'h1;
                    end
                end
                ST_TACK: begin
                    if (ack_seen_r) begin
                        bit_cnt_r <= 4'h1;
                        state_r   <= ST_TX;
                        if (!byte_sel_r) begin
                            tx_sh_r    <= {hold_r[6:0], 1'b0};
                            sda_low_r  <= ~hold_r[7];
                            byte_sel_r <= 1'b1;
                            idx_r      <= idx_r + 16'h0001;
                        end else begin
                            hold_r     <= reg_rd_data;
                            tx_sh_r    <= {reg_rd_data[14:8], 1'b0};
                            sda_low_r  <= ~reg_rd_data[15];
                            byte_sel_r <= 1'b0;
                        end
                    end else begin
                        // bus left released until stop or start
                        state_r <= ST_IGN;
                    end
                end
                default: begin
                    sda_low_r <= 1'b0;
                end
            endcase
        end
    end

    // Three-wire holding register; no bit count, only the last 32 bits matter
    // waits through pauses
    always @(posedge clk) begin
        if (srst) begin
            frame_r <= 32'h00000000;
        end else if (!two_wire && !filt_r[CS_B] && scl_rise) begin
            frame_r <= {frame_r[30:0], filt_r[SDA_B]};
        end
    end

    // Write request from either mode, decided combinationally
    always @* begin
        wr_req      = 1'b0;
        wr_req_idx  = idx_r;
        wr_req_data = {dat_hi_r, rx_sh_r};
        if (two_wire) begin
            // data word complete on its second byte
            wr_req = scl_fall && (state_r == ST_WRX) && (bit_cnt_r == 4'h8)
                     && (wbyte_r == `DMSCP_WB_DAT_LO);
        end else begin
            wr_req      = cs_rise;
            wr_req_idx  = frame_r[31:16];
            wr_req_data = frame_r[15:0];
        end
    end

    // Register write strobe; dropped while power-on hold is active
    always @(posedge clk) begin
        if (srst) begin
            wr_r      <= 1'b0;
            swr_r     <= 1'b0;
            wr_idx_r  <= 16'h0000;
            wr_data_r <= 16'h0000;
        end else begin
            wr_r  <= wr_req & por_done_r;
            swr_r <= wr_req & por_done_r & (wr_req_idx == `DMSCP_REG_SW_RESET);
            if (wr_req && por_done_r) begin
                wr_idx_r  <= wr_req_idx;
                wr_data_r <= wr_req_data;
            end
        end
    end

    // open-drain data only; clock line has no driver here
    assign sda_out     = 1'b0;
    assign sda_oe      = sda_low_r;
    assign reg_rd_idx  = idx_r;
    assign reg_wr      = wr_r;
    assign reg_wr_idx  = wr_idx_r;
    assign reg_wr_data = wr_data_r;
    assign sw_reset    = swr_r;
    assign por_done    = por_done_r;

endmodule // dmscp_port
`default_nettype wire

//--- verification/dmscp_host.sv
`timescale 1ns/1ns
`default_nettype none
// Bus master: bit-bangs both link modes off the core clock
module dmscp_host (
    input  wire logic clk,
    input  wire logic sda_in,
    output var  logic scl,
    output var  logic sda,
    output var  logic strap,
    output var  logic mode
);
    // Stall inside each frame longer than 16 bits, in quarter periods
    localparam int PAUSE = 37;
    initial {scl, sda, strap, mode} = 4'hf;
    // Quarter of the 160 ns period, launched just after a core edge
    task automatic q(input int n = 1);
        repeat (4 * n) @(posedge clk);
        #1;
    endtask
    // Strap before mode, so no false select edge reaches three-wire mode
    task automatic set_mode(input logic m, input logic s);
        strap = s;
        q();
        {mode, scl, sda} = {m, m, 1'b1};
        q(3);
    endtask
    // start and stop as steps of clock and data
    task automatic pins(input logic [7:0] v, input int n);
        for (int k = 3; k > 3 - n; k--) begin
            {scl, sda} = v[2*k +: 2];
            q();
        end
    endtask
    // eight bits then the acknowledge slot
    task automatic xbyte(input logic [7:0] d, input logic ah, output logic [7:0] r,
                         output logic ak);
        for (int i = 7; i >= -1; i--) begin
            sda = (i < 0) ? ah : d[i];
            q();
            scl = 1'b1;
            q();
            if (i >= 0) r[i] = sda_in;
            else ak = sda_in;
            q();
            scl = 1'b0;
            q();
        end
    endtask
    task automatic frame(input logic [31:0] f, input int n);
        strap = 1'b0;
        q();
        for (int i = n - 1; i >= 0; i--) begin
            sda = f[i];
            q();
            scl = 1'b1;
            q(2);
            scl = 1'b0;
            if (i == 16) q(PAUSE);
            q();
        end
        // Select rises to commit; released line shows the inverse
        strap = 1'b1;
        sda = ~sda;
        q(2);
    endtask
endmodule // dmscp_host
`default_nettype wire

//--- verification/dmscp_port_chk.sv
`timescale 1ns/1ns
`default_nettype none
module dmscp_port_chk (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        mode_strap,
    input wire logic        select_addr_strap,
    input wire logic        scl_in,
    input wire logic        sda_in,
    input wire logic        sda_out,
    input wire logic        sda_oe,
    input wire logic [15:0] reg_rd_idx,
    input wire logic [15:0] reg_rd_data,
    input wire logic        reg_wr,
    input wire logic [15:0] reg_wr_idx,
    input wire logic [15:0] reg_wr_data,
    input wire logic        sw_reset,
    input wire logic        por_done
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    // Cycles since reset release; saturates so it never wraps
    logic [11:0] cnt_r;
    always_ff @(posedge clk) begin
        if (srst) cnt_r <= 12'h000;
        else if (cnt_r != 12'hfff) cnt_r <= cnt_r + 12'h001;
    end
    // Three-wire commit: select rises, then a single write cycle
    sequence sel_rise_s;
        !mode_strap && $rose(select_addr_strap) && por_done;
    endsequence
    sequence one_wr_s;
        reg_wr ##1 !reg_wr;
    endsequence
    // Port relations
    drain_only_a: assert property (sda_out == 1'b0)
        else $error("data pin driven high");
    oe_clk_low_a: assert property (
        $changed(sda_oe) && !$past(srst) |-> !scl_in) else $error("data moved, clock high");
    spi_quiet_a: assert property ((!mode_strap) [*8] |-> !sda_oe)
        else $error("data driven in three-wire mode");
    frame_commit_a: assert property (sel_rise_s |-> ##[2:8] one_wr_s)
        else $error("no single write after select rise");
    wr_hold_a: assert property (
        !reg_wr && !$past(srst) |-> $stable({reg_wr_idx, reg_wr_data}))
        else $error("write index or data moved");
    sw_pair_a: assert property (sw_reset == (reg_wr && reg_wr_idx == 16'h0000))
        else $error("reset strobe not tied to index zero");
    por_gate_a: assert property (reg_wr |-> por_done)
        else $error("write during startup hold");
    por_hold_a: assert property (cnt_r < 12'd599 |-> !por_done)
        else $error("startup hold too short");
    por_rise_a: assert property (cnt_r > 12'd601 |-> por_done)
        else $error("startup hold too long");
endmodule // dmscp_port_chk
bind dmscp_port dmscp_port_chk u_chk (
    .clk(clk), .srst(srst), .mode_strap(mode_strap), .select_addr_strap(select_addr_strap),
    .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe),
    .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .reg_wr(reg_wr),
    .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .sw_reset(sw_reset),
    .por_done(por_done));
`default_nettype wire

//--- verification/dmscp_port_tb_top.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin mismatches++; \
    $display("FAIL t=%0t got=%0h exp=%0h", $time, (a), (b)); end end
module dmscp_port_tb_top;
    // Register file answers with a fixed scramble of the index
    localparam logic [15:0] MIX = 16'h5a3c;
    localparam logic [7:0]  P_START = 8'h78;
    localparam logic [7:0]  P_STOP = 8'h2c;
    logic        clk, srst, scl, sda_h, strap, mode, sda_out, sda_oe, reg_wr, sw_reset;
    logic        por_done, k, m, s;
    logic [15:0] reg_rd_idx, reg_wr_idx, reg_wr_data, idx, dat;
    logic [31:0] last_wr, rd;
    logic [33:0] rows [6];
    logic [4:0]  ak;
    logic [7:0]  r;
    int          n_wr, n_sw, w0, s0, mismatches, n_checks;
    // Open-drain data line with pull-up
    wire logic        sda_bus = sda_h & ~sda_oe;
    wire logic [15:0] reg_rd_data = reg_rd_idx ^ MIX;
    dmscp_port u_dut (
        .clk(clk), .srst(srst), .mode_strap(mode), .select_addr_strap(strap),
        .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_out), .sda_oe(sda_oe),
        .reg_rd_idx(reg_rd_idx), .reg_rd_data(reg_rd_data), .reg_wr(reg_wr),
        .reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .sw_reset(sw_reset),
        .por_done(por_done));
    dmscp_host u_host (
        .clk(clk), .sda_in(sda_bus), .scl(scl), .sda(sda_h), .strap(strap), .mode(mode));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Write log kept by the outside register file
    always @(posedge clk) begin
        if (reg_wr) last_wr <= {reg_wr_idx, reg_wr_data};
        if (reg_wr) n_wr <= n_wr + 1;
        if (sw_reset) n_sw <= n_sw + 1;
    end
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // start, address, index and data bytes; caller decides how to end
    task automatic tw_wr(input logic [6:0] a, input logic [15:0] i, input logic [15:0] d,
                         input int nb);
        logic [39:0] w;
        w = {a, 1'b0, i, d};
        ak = 5'h00;
        u_host.pins(P_START, 4);
        for (int b = 4; b > 4 - nb; b--) begin
            u_host.xbyte(w[8*b +: 8], 1'b1, r, k);
            ak[b] = k;
        end
    endtask
    // Hang guard, several times the expected run
    initial begin
        #500_000;
        mismatches++;
        end_of_test();
    end
    initial begin
        srst = 1'b1;
        repeat (10) @(posedge clk);
        #1 srst = 1'b0;
        // Short frame lands inside the startup hold and is dropped
        u_host.set_mode(1'b0, 1'b1);
        u_host.frame(32'h0000_0042, 8);
        `CHK(n_wr, 0)
        `CHK(por_done, 1'b0)
        repeat (600) @(posedge clk);
        `CHK(por_done, 1'b1)
        $display("test startup hold done");
        rows = '{34'h2_1234_abcd, 34'h3_ffff_8001, 34'h3_0000_0000,
                 34'h1_8421_7e5a, 34'h1_0000_1111, 34'h1_00ff_ff00};
        foreach (rows[j]) begin
            {m, s, idx, dat} = rows[j];
            w0 = n_wr;
            s0 = n_sw;
            ak = 5'h00;
            u_host.set_mode(m, s);
            if (m) tw_wr({6'h0e, s}, idx, dat, 5);
            else u_host.frame({idx, dat}, 32);
            if (m) u_host.pins(P_STOP, 3);
            u_host.q(2);
            `CHK(ak, 5'h00)
            `CHK(n_wr - w0, 1)
            `CHK(last_wr, {idx, dat})
            `CHK(n_sw - s0, int'(idx == 16'h0000))
        end
        $display("test table done");
        // Address of the other strap setting is not ours
        w0 = n_wr;
        u_host.set_mode(1'b1, 1'b0);
        tw_wr(7'h1d, 16'h0042, 16'h0042, 5);
        u_host.pins(P_STOP, 3);
        `CHK(ak, 5'h1f)
        `CHK(n_wr - w0, 0)
        $display("test foreign address done");
        // read across the top index, host refuses the last byte
        tw_wr(7'h1c, 16'hffff, 16'h0000, 3);
        u_host.pins(P_START, 4);
        u_host.xbyte(8'h39, 1'b1, r, k);
        `CHK({ak, k}, 6'h00)
        for (int j = 0; j < 4; j++) begin
            u_host.xbyte(8'hff, j == 3, r, k);
            rd = {rd[23:0], r};
        end
        u_host.pins(P_STOP, 3);
        `CHK(rd, {16'hffff ^ MIX, MIX})
        `CHK(sda_oe, 1'b0)
        $display("test read wrap done");
        // Reset in mid-run restarts the hold
        srst = 1'b1;
        repeat (3) @(posedge clk);
        #1 srst = 1'b0;
        `CHK(por_done, 1'b0)
        `CHK(reg_rd_idx, 16'h0000)
        repeat (2) @(posedge clk);
        #1;
        `CHK(por_done, 1'b0)
        `CHK(sda_oe, 1'b0)
        $display("test mid-run reset done");
        end_of_test();
    end
endmodule // dmscp_port_tb_top
`default_nettype wire
